//--- src/tlc_codec.sv
/*
  test-loop message codec: decodes a downlink unit, builds the matching
  uplink confirmation and shifts it out msb first.
  assumes: rx unit is msb-aligned with its bit count; link layer sends
  the tx bits in basic frames without a check sequence.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - confirm status 00 active, 01 unset, 10 unsupported
// - full power classes coded 0001 to 0101
// - reduced variants set top bit, 1001-1101
// - replies tagged with four uplink codes
// - receiver category 00 A, 01 B, 10 E
// - unit begins with discriminator 111
// - no frame check sequence added or checked
// - units handed down to link layer unchanged
// - no control of rf loopback mode
// - each command answered by matching confirmation
// - loop closed echoes received loopback type
// - loopback type 00001 plain, 00010 erasure
// - confirmation field order type to capability
module tlc_codec (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  // received unit from link layer
  input  wire logic                     rx_valid,
  input  wire tlc_pkg::tlc_unit_type    rx_unit,
  // terminal configuration
  input  wire tlc_pkg::tlc_terminal_type term_cfg,
  // transmit bits to link layer
  output logic                          tx_bit,
  output logic                          tx_bit_valid,
  output logic                          tx_bit_last,
  // status
  output logic                          rx_ready,
  output logic                          loop_closed,
  output logic [tlc_pkg::LOOP_W-1:0]    loop_type,
  output logic                          erasure_ind,
  output logic                          drop_pulse
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} tlc_state_type;

  // ***************************************************************
  // state
  // ***************************************************************
  tlc_state_type             st_reg, st_next;         // control state
  tlc_pkg::tlc_unit_type     tx_reg, tx_next;         // built reply
  logic                      lc_reg, lc_next;         // loop closed
  logic [tlc_pkg::LOOP_W-1:0] lt_reg, lt_next;        // loopback type
  logic                      er_reg, er_next;         // erasure indication
  logic                      dr_reg, dr_next;         // drop pulse
  logic                      rdy_reg, rdy_next;       // ready for unit
  logic                      ser_busy;                // serializer busy
  logic                      ser_bit, ser_valid, ser_last;
  logic                      load;                    // start shift
  logic [tlc_pkg::DISC_W-1:0] rx_disc;                // received discriminator
  logic [tlc_pkg::TYPE_W-1:0] rx_type;                // received type
  logic [tlc_pkg::LOOP_W-1:0] rx_loop;                // received loopback type
  logic [tlc_pkg::CONF_W-1:0] conf;                   // confirm status
  logic [tlc_pkg::PWR_W-1:0]  pwr;                    // power class code

  // ***************************************************************
  // field extraction, msb-aligned
  // ***************************************************************
  assign rx_disc = rx_unit.bits[tlc_pkg::UNIT_W-1 -: tlc_pkg::DISC_W];
  assign rx_type = rx_unit.bits[tlc_pkg::UNIT_W-1-tlc_pkg::DISC_W -: tlc_pkg::TYPE_W];
  assign rx_loop = rx_unit.bits[tlc_pkg::UNIT_W-1-tlc_pkg::DISC_W-tlc_pkg::TYPE_W
                                -: tlc_pkg::LOOP_W];

  // ***************************************************************
  // field encoders
  // ***************************************************************
  always_comb begin
    // confirm status encoding
    if (!term_cfg.tm_supported) begin
      conf = tlc_pkg::CONF_UNSUPPORTED;
    end else if (term_cfg.tm_active) begin
      conf = tlc_pkg::CONF_ACTIVE;
    end else begin
      conf = tlc_pkg::CONF_NOT_SET;
    end
    // power class: low bits class, top bit reduced variant
    pwr = {term_cfg.pwr_reduced, term_cfg.pwr_class};
    if (term_cfg.pwr_class < tlc_pkg::PWR_CLASS_MIN) begin
      pwr[2:0] = tlc_pkg::PWR_CLASS_MIN;
    end else if (term_cfg.pwr_class > tlc_pkg::PWR_CLASS_MAX) begin
      pwr[2:0] = tlc_pkg::PWR_CLASS_MAX;
    end
  end

  // ***************************************************************
  // command decode and reply build
  // ***************************************************************
  always_comb begin
    st_next  = st_reg;
    tx_next  = tx_reg;
    lc_next  = lc_reg;
    lt_next  = lt_reg;
    er_next  = er_reg;
    dr_next  = 1'b0;
    rdy_next = rdy_reg;
    case (st_reg)
      ST_IDLE: begin
        rdy_next = 1'b1;
        if (rx_valid && rdy_reg) begin
          rdy_next = 1'b0;
          st_next  = ST_LOAD;
          tx_next.bits = '0;
          // no check sequence is looked for or stripped
          if (rx_disc != tlc_pkg::DISC_TEST_LOOP || rx_unit.len < tlc_pkg::LEN_MIN_RX) begin
            // not a test-loop unit, or shorter than LEN_MIN_RX
            dr_next  = 1'b1;
            st_next  = ST_IDLE;
            rdy_next = 1'b1;
          end else begin
            case (rx_type) // downlink codes
              tlc_pkg::CMD_CLOSE_LOOP: begin
                // echo loopback type
                tx_next.bits[tlc_pkg::UNIT_W-1 -: 13] =
                  {tlc_pkg::DISC_TEST_LOOP, tlc_pkg::RSP_LOOP_CLOSED, rx_loop};
                tx_next.len = tlc_pkg::LEN_LOOP;
                lc_next = 1'b1;
                lt_next = rx_loop;
                er_next = (rx_loop == tlc_pkg::LOOP_ERASURE);
              end
              tlc_pkg::CMD_OPEN_LOOP: begin
                tx_next.bits[tlc_pkg::UNIT_W-1 -: 8] =
                  {tlc_pkg::DISC_TEST_LOOP, tlc_pkg::RSP_LOOP_OPENED};
                tx_next.len = tlc_pkg::LEN_SHORT;
                lc_next = 1'b0;
                er_next = 1'b0;
              end
              tlc_pkg::CMD_CONFIRM_TM: begin
                // type, status, identity, power, category, capability
                tx_next.bits[tlc_pkg::UNIT_W-1 -: 100] =
                  {tlc_pkg::DISC_TEST_LOOP, tlc_pkg::RSP_TM_CONFIRM, conf,
                   term_cfg.identity, pwr, term_cfg.rx_cat, term_cfg.capability};
                tx_next.len = tlc_pkg::LEN_CONF;
              end
              tlc_pkg::CMD_END_TM: begin
                tx_next.bits[tlc_pkg::UNIT_W-1 -: 8] =
                  {tlc_pkg::DISC_TEST_LOOP, tlc_pkg::RSP_TM_ENDED};
                tx_next.len = tlc_pkg::LEN_SHORT;
                lc_next = 1'b0;
                er_next = 1'b0;
              end
              default: begin
                // unknown type: silent discard
                dr_next  = 1'b1;
                st_next  = ST_IDLE;
                rdy_next = 1'b1;
              end
            endcase
          end
        end
      end
      ST_LOAD: begin
        st_next = ST_SEND;
      end
      ST_SEND: begin
        // reply bits go to link layer as built
        if (!ser_busy) begin
          st_next  = ST_IDLE;
          rdy_next = 1'b1;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  assign load = (st_reg == ST_LOAD);

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg  <= ST_IDLE;
      tx_reg  <= '0;
      lc_reg  <= 1'b0;
      lt_reg  <= '0;
      er_reg  <= 1'b0;
      dr_reg  <= 1'b0;
      rdy_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      tx_reg  <= tx_next;
      lc_reg  <= lc_next;
      lt_reg  <= lt_next;
      er_reg  <= er_next;
      dr_reg  <= dr_next;
      rdy_reg <= rdy_next;
    end
  end

  // ***************************************************************
  // serializer
  // ***************************************************************
  tlc_serializer u_ser (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .load      (load),
    .unit_in   (tx_reg),
    .busy      (ser_busy),
    .bit_out   (ser_bit),
    .bit_valid (ser_valid),
    .bit_last  (ser_last)
  );

  // ***************************************************************
  // outputs; loop state only, no rf loopback control
  // ***************************************************************
  assign tx_bit       = ser_bit;
  assign tx_bit_valid = ser_valid;
  assign tx_bit_last  = ser_last;
  assign rx_ready     = rdy_reg;
  assign loop_closed  = lc_reg;
  assign loop_type    = lt_reg;
  assign erasure_ind  = er_reg;
  assign drop_pulse   = dr_reg;
endmodule
`default_nettype wire

//--- pkg/tlc_pkg.sv
/*
  test-loop message codec package: type codes, field widths, field encodings,
  discriminator and message structs.
  assumes: single clock domain, synchronous active-high reset.
*/
package tlc_pkg;

  // ***************************************************************
  // field widths
  // ***************************************************************
  localparam int DISC_W   = 3;    // protocol discriminator width
  localparam int TYPE_W   = 5;    // message type width
  localparam int LOOP_W   = 5;    // loopback type width
  localparam int CONF_W   = 2;    // confirm status width
  localparam int IDENT_W  = 60;   // equipment identity width
  localparam int PWR_W    = 4;    // power class width
  localparam int RXC_W    = 2;    // receiver category width
  localparam int CAP_W    = 24;   // terminal capability width
  localparam int UNIT_W   = 128;  // longest unit with discriminator
  localparam int LEN_W    = 8;    // bit count width

  // ***************************************************************
  // discriminator and type codes
  // ***************************************************************
  localparam logic [DISC_W-1:0] DISC_TEST_LOOP = 3'h7;
  localparam logic [TYPE_W-1:0] CMD_CLOSE_LOOP = 5'h04;
  localparam logic [TYPE_W-1:0] CMD_OPEN_LOOP  = 5'h07;
  localparam logic [TYPE_W-1:0] CMD_CONFIRM_TM = 5'h0E;
  localparam logic [TYPE_W-1:0] CMD_END_TM     = 5'h10;
  localparam logic [TYPE_W-1:0] RSP_LOOP_CLOSED = 5'h05;
  localparam logic [TYPE_W-1:0] RSP_LOOP_OPENED = 5'h08;
  localparam logic [TYPE_W-1:0] RSP_TM_CONFIRM  = 5'h0F;
  localparam logic [TYPE_W-1:0] RSP_TM_ENDED    = 5'h11;

  // ***************************************************************
  // field encodings
  // ***************************************************************
  localparam logic [CONF_W-1:0] CONF_ACTIVE      = 2'h0;
  localparam logic [CONF_W-1:0] CONF_NOT_SET     = 2'h1;
  localparam logic [CONF_W-1:0] CONF_UNSUPPORTED = 2'h2;
  localparam logic [RXC_W-1:0]  RXC_A = 2'h0;
  localparam logic [RXC_W-1:0]  RXC_B = 2'h1;
  localparam logic [RXC_W-1:0]  RXC_E = 2'h2;
  localparam logic [LOOP_W-1:0] LOOP_NO_ERASURE = 5'h01;
  localparam logic [LOOP_W-1:0] LOOP_ERASURE    = 5'h02;
  localparam logic [2:0]        PWR_CLASS_MIN = 3'h1;
  localparam logic [2:0]        PWR_CLASS_MAX = 3'h5;
  localparam int                PWR_REDUCED_BIT = 3;

  // ***************************************************************
  // unit lengths in bits, discriminator included
  // ***************************************************************
  localparam logic [LEN_W-1:0] LEN_SHORT = 8'h08;  // 3 + 5
  localparam logic [LEN_W-1:0] LEN_LOOP  = 8'h0D;  // 3 + 5 + 5
  localparam logic [LEN_W-1:0] LEN_CONF  = 8'h64;  // 3 + 5 + 2 + 60 + 4 + 2 + 24
  localparam logic [LEN_W-1:0] LEN_MIN_RX = 8'h08;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic [IDENT_W-1:0] identity;    // equipment identity number
    logic [2:0]         pwr_class;   // class 1..5
    logic               pwr_reduced; // reduced-power variant
    logic [RXC_W-1:0]   rx_cat;      // receiver category
    logic [CAP_W-1:0]   capability;  // terminal capability
    logic               tm_supported;// test mode supported
    logic               tm_active;   // test mode set
  } tlc_terminal_type;

  typedef struct packed {
    logic [UNIT_W-1:0] bits;  // msb-aligned unit, first bit at top
    logic [LEN_W-1:0]  len;   // valid bit count
  } tlc_unit_type;

endpackage

//--- src/tlc_serializer.sv
/*
  msb-first bit serializer for one link unit.
  assumes: load only while idle; consumer takes a bit each bit_valid cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module tlc_serializer (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // unit in
  input  wire logic                 load,
  input  wire tlc_pkg::tlc_unit_type unit_in,
  // bits out
  output logic                      busy,
  output logic                      bit_out,
  output logic                      bit_valid,
  output logic                      bit_last
);
  logic [tlc_pkg::UNIT_W-1:0] sh_reg, sh_next;   // shift register
  logic [tlc_pkg::LEN_W-1:0]  cnt_reg, cnt_next; // bits left
  logic                       b_reg, b_next;
  logic                       v_reg, v_next;
  logic                       l_reg, l_next;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    sh_next  = sh_reg;
    cnt_next = cnt_reg;
    b_next   = 1'b0;
    v_next   = 1'b0;
    l_next   = 1'b0;
    if (load && cnt_reg == '0) begin
      // capture unit
      sh_next  = unit_in.bits;
      cnt_next = unit_in.len;
    end else if (cnt_reg != '0) begin
      // emit top bit, no padding between fields
      b_next   = sh_reg[tlc_pkg::UNIT_W-1];
      v_next   = 1'b1;
      l_next   = (cnt_reg == 8'h01);
      sh_next  = {sh_reg[tlc_pkg::UNIT_W-2:0], 1'b0};
      cnt_next = cnt_reg - 8'h01;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sh_reg  <= '0;
      cnt_reg <= '0;
      b_reg   <= 1'b0;
      v_reg   <= 1'b0;
      l_reg   <= 1'b0;
    end else begin
      sh_reg  <= sh_next;
      cnt_reg <= cnt_next;
      b_reg   <= b_next;
      v_reg   <= v_next;
      l_reg   <= l_next;
    end
  end

  assign busy      = (cnt_reg != '0) || v_reg;
  assign bit_out   = b_reg;
  assign bit_valid = v_reg;
  assign bit_last  = l_reg;
endmodule
`default_nettype wire

//--- dv/tlc_codec_sva.sv
/*
  checker for the test-loop codec, bound to its top ports.
  assumes: one clock, sync active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tlc_codec_sva (
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       reset,
  // downlink and config
  input wire logic                       rx_valid,
  input wire tlc_pkg::tlc_unit_type      rx_unit,
  input wire tlc_pkg::tlc_terminal_type  term_cfg,
  // reply and status
  input wire logic                       tx_bit,
  input wire logic                       tx_bit_valid,
  input wire logic                       tx_bit_last,
  input wire logic                       rx_ready,
  input wire logic                       loop_closed,
  input wire logic [tlc_pkg::LOOP_W-1:0] loop_type,
  input wire logic                       erasure_ind,
  input wire logic                       drop_pulse
);
  // ***
  // helpers
  // ***
  logic       acc;      // unit taken
  logic       ok;       // taken, good discriminator and length
  logic       known;    // type is a downlink command
  logic [4:0] typ;      // received type
  logic [4:0] loop_cap; // loopback type last taken
  logic [1:0] conf_cap; // status the reply must carry
  assign acc = rx_valid && rx_ready;
  assign typ = rx_unit.bits[124:120];
  assign ok = acc && rx_unit.bits[127:125] == 3'h7 && rx_unit.len >= 8'h08;
  assign known = typ inside {tlc_pkg::CMD_CLOSE_LOOP, tlc_pkg::CMD_OPEN_LOOP,
                             tlc_pkg::CMD_CONFIRM_TM, tlc_pkg::CMD_END_TM};
  // capture fields at the accept edge
  always_ff @(posedge clk_sys) begin
    if (acc) begin
      loop_cap <= rx_unit.bits[119:115];
      conf_cap <= !term_cfg.tm_supported ? 2'h2 : (term_cfg.tm_active ? 2'h0 : 2'h1);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_BAD_UNIT: assert property (acc && !ok |=> drop_pulse && !tx_bit_valid)
    else $error("bad unit not dropped");
  AST_UNKNOWN_DROP: assert property (ok && !known |=> drop_pulse && rx_ready && !tx_bit_valid)
    else $error("unknown type not dropped");
  AST_DISC_FIRST: assert property (ok && known |=> !drop_pulse ##2 (tx_bit_valid && tx_bit)[*3])
    else $error("reply lacks discriminator");
  AST_OPEN_REPLY: assert property (ok && typ == tlc_pkg::CMD_OPEN_LOOP |->
    ##3 (tx_bit_valid && !tx_bit_last)[*7] ##1 (tx_bit_valid && tx_bit_last))
    else $error("open reply length wrong");
  AST_LOOP_ECHO: assert property (ok && typ == tlc_pkg::CMD_CLOSE_LOOP |->
    ##11 tx_bit == loop_cap[4] ##4 tx_bit_last && tx_bit == loop_cap[0])
    else $error("loopback type not echoed");
  AST_CONF_STATUS: assert property (ok && typ == tlc_pkg::CMD_CONFIRM_TM |->
    ##11 tx_bit == conf_cap[1] ##1 tx_bit == conf_cap[0] ##90 tx_bit_last)
    else $error("confirm status or length wrong");
  AST_BITS_RUN: assert property (tx_bit_valid && !tx_bit_last |=> tx_bit_valid)
    else $error("gap inside reply");
  AST_LOOP_CLEARED: assert property (ok && (typ == tlc_pkg::CMD_OPEN_LOOP ||
    typ == tlc_pkg::CMD_END_TM) |-> ##[1:16] !loop_closed)
    else $error("loop not opened");
  AST_ERASURE: assert property (erasure_ind |-> loop_closed && loop_type == 5'h02)
    else $error("erasure flag without erasure loop");
endmodule
bind tlc_codec tlc_codec_sva u_tlc_codec_sva (.clk_sys(clk_sys), .reset(reset),
  .rx_valid(rx_valid), .rx_unit(rx_unit), .term_cfg(term_cfg), .tx_bit(tx_bit),
  .tx_bit_valid(tx_bit_valid), .tx_bit_last(tx_bit_last), .rx_ready(rx_ready),
  .loop_closed(loop_closed), .loop_type(loop_type), .erasure_ind(erasure_ind),
  .drop_pulse(drop_pulse));
`default_nettype wire

//--- dv/tlc_tss_model.sv
/*
  test system simulator model: offers downlink units, collects replies.
  assumes: codec takes a unit when rx_valid and rx_ready are high.
*/
`timescale 1ns/1ps
`default_nettype none
module tlc_tss_model (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            reset,
  // downlink unit
  output logic                 rx_valid,
  output tlc_pkg::tlc_unit_type rx_unit,
  input  wire logic            rx_ready,
  // uplink bits
  input  wire logic            tx_bit,
  input  wire logic            tx_bit_valid,
  input  wire logic            tx_bit_last,
  // collected reply
  output logic [127:0]         got_bits,
  output logic [7:0]           got_len
);
  logic got_done; // previous reply complete
  initial begin
    rx_valid = 1'b0;
    rx_unit = '0;
  end
  // collector: the first bit of a reply restarts the shift
  always @(posedge clk_sys) begin
    if (reset) begin
      got_bits <= '0;
      got_len <= '0;
      got_done <= 1'b1;
    end else if (tx_bit_valid === 1'b1) begin
      got_bits <= got_done ? {127'h0, tx_bit} : {got_bits[126:0], tx_bit};
      got_len <= got_done ? 8'h01 : got_len + 8'h01;
      got_done <= tx_bit_last;
    end
  end
  // offer one unit; no check sequence; released lines show the inverse
  task automatic send(input logic [127:0] b, input logic [7:0] n, output logic ok);
    int k;
    rx_unit <= '{bits: b, len: n};
    rx_valid <= 1'b1;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (rx_ready !== 1'b1 && k < 50);
    ok = (rx_ready === 1'b1);
    rx_valid <= 1'b0;
    rx_unit <= '{bits: ~b, len: ~n};
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
/*
  self-checking bench for the test-loop codec.
  assumes: package compiled first; checker bound by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  // ***
  // signals
  // ***
  logic                       clk_sys, reset, rx_valid, rx_ready;
  logic                       tx_bit, tx_bit_valid, tx_bit_last;
  logic                       loop_closed, erasure_ind, drop_pulse;
  logic [tlc_pkg::LOOP_W-1:0] loop_type;
  logic [127:0]               got_bits;
  logic [7:0]                 got_len;
  tlc_pkg::tlc_unit_type      rx_unit;
  tlc_pkg::tlc_terminal_type  term_cfg;
  int err_count = 0, n_compared = 0;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  tlc_codec u_tlc_codec (.clk_sys(clk_sys), .reset(reset), .rx_valid(rx_valid),
    .rx_unit(rx_unit), .term_cfg(term_cfg), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_bit_last(tx_bit_last), .rx_ready(rx_ready), .loop_closed(loop_closed),
    .loop_type(loop_type), .erasure_ind(erasure_ind), .drop_pulse(drop_pulse));
  tlc_tss_model u_tlc_tss_model (.clk_sys(clk_sys), .reset(reset), .rx_valid(rx_valid),
    .rx_unit(rx_unit), .rx_ready(rx_ready), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_bit_last(tx_bit_last), .got_bits(got_bits), .got_len(got_len));
  // ***
  // tasks
  // ***
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one command, then its reply or its drop; zero length means drop
  task automatic run(input logic [127:0] cmd, input logic [7:0] n,
                     input logic [127:0] ex, input logic [7:0] ex_len);
    logic ok;
    int k, d;
    logic [7:0] l;
    d = 0;
    l = got_len;
    u_tlc_tss_model.send(cmd, n, ok);
    k = 0;
    // drop pulses are counted here, on the value that stood before each edge
    do begin
      @(posedge clk_sys);
      k++;
      if (drop_pulse === 1'b1) begin
        d++;
      end
    end while (rx_ready !== 1'b1 && k < 200);
    if (!ok || k >= 200) begin
      err_count++;
      end_sim();
    end
    if (ex_len == 8'h00) begin
      `CHK("drop count", 1, d)
      `CHK("no reply", l, got_len)
    end else begin
      `CHK("no drop", 0, d)
      `CHK("reply length", ex_len, got_len)
      `CHK("reply bits", ex, got_bits)
    end
  endtask
  task automatic t_open();
    run({3'h7, tlc_pkg::CMD_OPEN_LOOP, 120'h0}, 8'h08, {120'h0, 3'h7, 5'h08}, 8'h08);
    `CHK("loop closed", 1'b0, loop_closed)
  endtask
  task automatic t_close();
    logic [4:0] lt;
    for (int i = 1; i <= 2; i++) begin
      lt = i[4:0];
      run({3'h7, tlc_pkg::CMD_CLOSE_LOOP, lt, 115'h0}, 8'h0D,
          {115'h0, 3'h7, 5'h05, lt}, 8'h0D);
      `CHK("loop closed", 1'b1, loop_closed)
      `CHK("loop type", lt, loop_type)
      `CHK("erasure", lt == 5'h02, erasure_ind)
    end
  endtask
  // mid-run reset clears loop state; ready comes back one edge after release
  task automatic t_reset();
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("ready in reset", 1'b0, rx_ready)
    reset <= 1'b0;
    @(posedge clk_sys);
    `CHK("loop after reset", 1'b0, loop_closed)
    `CHK("erasure after reset", 1'b0, erasure_ind)
    `CHK("ready at release", 1'b0, rx_ready)
    @(posedge clk_sys);
    `CHK("ready after reset", 1'b1, rx_ready)
  endtask
  task automatic t_end();
    run({3'h7, tlc_pkg::CMD_END_TM, 120'h0}, 8'h08, {120'h0, 3'h7, 5'h11}, 8'h08);
    `CHK("loop closed", 1'b0, loop_closed)
  endtask
  // all ten power codes, three receiver categories, three status cases
  task automatic t_conf();
    logic [59:0] id;
    logic [23:0] cap;
    logic [3:0] pw;
    logic [1:0] cf;
    for (int i = 0; i < 10; i++) begin
      id = 60'hA5A5A5A5A5A5A50 + 60'(i);
      cap = 24'hC3C300 + 24'(i);
      pw = {i[0], 3'(i / 2 + 1)};
      cf = (i == 9) ? 2'h2 : ((i < 4) ? 2'h0 : 2'h1);
      term_cfg <= '{id, pw[2:0], pw[3], 2'(i % 3), cap, i != 9, i < 4 || i == 9};
      run({3'h7, tlc_pkg::CMD_CONFIRM_TM, 120'h0}, 8'h08,
          {28'h0, 3'h7, 5'h0F, cf, id, pw, 2'(i % 3), cap}, 8'h64);
    end
  endtask
  task automatic t_drop();
    run({3'h6, tlc_pkg::CMD_OPEN_LOOP, 120'h0}, 8'h08, 128'h0, 8'h00);
    run({3'h7, 5'h05, 120'h0}, 8'h08, 128'h0, 8'h00);
    run({3'h7, tlc_pkg::CMD_OPEN_LOOP, 120'h0}, 8'h05, 128'h0, 8'h00);
  endtask
  initial begin
    reset = 1'b1;
    term_cfg = '0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_open();
    t_close();
    t_reset();
    t_close();
    t_open();
    t_close();
    t_end();
    t_conf();
    t_drop();
    end_sim();
  end
endmodule
`default_nettype wire
